// ==== annp_partner_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// remote partner: repeats code words and consumes our pages
module annp_partner_model (
    input  wire logic   ref_clk,
    output logic        rxWordValid,
    output logic [15:0] rxWord,
    output logic        rxIsNextPage,
    output logic        txPageTaken
);
    // idle line at time zero
    initial begin
        rxWordValid  = 1'b0;
        rxWord       = 16'h0000;
        rxIsNextPage = 1'b0;
        txPageTaken  = 1'b0;
    end

    // send one word n times in a row; idle line shows the inverse
    task automatic send(input logic [15:0] w, input logic nxt, input int n);
        for (int i = 0; i < n; i++) begin
            rxWordValid  = 1'b1;
            rxWord       = w;
            rxIsNextPage = nxt;
            @(posedge ref_clk);
            #1;
        end
        rxWordValid = 1'b0;
        rxWord      = ~w;
        @(posedge ref_clk);
        #1;
    endtask

    // partner accepts one transmitted page
    task automatic take();
        txPageTaken = 1'b1;
        @(posedge ref_clk);
        #1;
        txPageTaken = 1'b0;
    endtask
endmodule

// ==== annp_pkg.sv ====
package annp_pkg;

    // ======================================================
    // next-page link code word layout
    typedef struct packed {
        logic        morePagesFlag;
        logic        ackFlag;
        logic        messagePageFlag;
        logic        taskCapableAck;
        logic        pageToggleBit;
        logic [10:0] pagePayload;
    } annp_page_t;

    // management access request
    typedef struct packed {
        logic        rdStrobe;
        logic        wrStrobe;
        logic [4:0]  addr;
        logic [15:0] wrData;
    } annp_mgmt_req_t;

    // management read state
    typedef enum logic [1:0] {
        ANNP_IDLE,
        ANNP_READ,
        ANNP_DONE
    } annp_rd_state_t;

endpackage

// ==== annp_regs.svh ====
`ifndef ANNP_REGS_SVH
`define ANNP_REGS_SVH

// ==========================================================
// register addresses on the management interface
`define ANNP_ADDR_PARTNER_WORD   5'h05
`define ANNP_ADDR_EXPANSION      5'h06
`define ANNP_ADDR_TRANSMIT_WORD  5'h07

// ==========================================================
// next-page word fields
`define ANNP_BIT_MORE_PAGES      15
`define ANNP_BIT_ACK             14
`define ANNP_BIT_MESSAGE_PAGE    13
`define ANNP_BIT_TASK_ACK        12
`define ANNP_BIT_TOGGLE          11
`define ANNP_PAYLOAD_MSB         10

// ==========================================================
// expansion fields
`define ANNP_BIT_PDFAULT         4
`define ANNP_BIT_PARTNER_NP      3
`define ANNP_BIT_LOCAL_NP        2
`define ANNP_BIT_PAGE_RCVD       1
`define ANNP_BIT_PARTNER_AN      0

// ==========================================================
// reset values and transmit write mask
`define ANNP_NULL_MESSAGE_CODE   11'h001
`define ANNP_TX_RESET            16'h2001
`define ANNP_TX_WRITE_MASK       16'hBFFF
`define ANNP_WORD_RESET          16'h0000

`endif

// ==== annp_word_store.sv ====
`timescale 1ns/100ps
`include "annp_regs.svh"

module annp_word_store (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        loadEn,
    input  wire logic [15:0] loadData,
    output logic      [15:0] wordOut
);

    // ======================================================
    // one-word store with registered output
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wordOut <= `ANNP_WORD_RESET;
        end else if (loadEn) begin
            wordOut <= loadData;
        end
    end

endmodule

// ==== autoneg_next_page_regs.sv ====
`timescale 1ns/100ps
`include "annp_regs.svh"

// Overview of operation
// - partner word bit 15: more pages follow
// - partner word bit 14: partner acknowledged
// - bit 13 selects message or unformatted page
// - bit 12: receiver can perform task
// - bit 11 inverts previous toggle value
// - bits 10-0 carry code or payload
// - parallel detect fault sets expansion bit 4
// - reading register 6 clears fault flag
// - expansion bit 3: partner next-page able
// - expansion bit 2: local next-page able
// - bit 1 sets after three identical words
// - reading register 6 clears page received
// - expansion bit 0: partner autoneg able
// - expansion register ignores management writes
// - null message page sent by default
// - pages continue until both sides finished
// - partner word loaded on the third identical received word
// - one location serves base and next

module autoneg_next_page_regs (
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire annp_pkg::annp_mgmt_req_t mgmtReq,
    output logic                         mgmtRdValid,
    output logic [15:0]                  mgmtRdData,
    input  wire logic                    rxWordValid,
    input  wire logic [15:0]             rxWord,
    input  wire logic                    rxIsNextPage,
    input  wire logic                    waitTimerDone,
    input  wire logic [1:0]              linkReadyCount,
    input  wire logic                    partnerAutonegAble,
    input  wire logic                    localNextPageAble,
    input  wire logic                    txPageTaken,
    output annp_pkg::annp_page_t         txPage,
    output logic                         localNextPageAdv,
    output logic                         exchangeDone,
    output logic                         partnerWordIsNext
);

    // ======================================================
    // local signals
    logic [15:0]              partnerWord;
    logic [15:0]              lastRxWord_reg;
    logic [1:0]               matchCount_reg;
    logic                     storeEn;
    logic                     pdFault_reg;
    logic                     pageRcvd_reg;
    logic                     partnerNp_reg;
    logic                     partnerAn_reg;
    logic                     localNp_reg;
    logic [15:0]              txWord_reg;
    logic                     prevToggle_reg;
    logic                     partnerMore_reg;
    logic                     readExp;
    logic                     writeTx;
    logic [15:0]              expWord;
    logic [15:0]              rdMux;
    annp_pkg::annp_rd_state_t rdState_reg;
    annp_pkg::annp_rd_state_t rdState_next;

    // decode one management address against a request
    function automatic logic hitAddr(input annp_pkg::annp_mgmt_req_t r,
                                     input logic [4:0] a);
        hitAddr = (r.addr == a);
    endfunction

    assign readExp = mgmtReq.rdStrobe && hitAddr(mgmtReq, `ANNP_ADDR_EXPANSION);
    assign writeTx = mgmtReq.wrStrobe && hitAddr(mgmtReq, `ANNP_ADDR_TRANSMIT_WORD);

    // ======================================================
    // received word qualification: three identical in a row
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lastRxWord_reg <= `ANNP_WORD_RESET;
            matchCount_reg <= 2'h0;
        end else if (rxWordValid) begin
            lastRxWord_reg <= rxWord;
            if (rxWord != lastRxWord_reg || matchCount_reg == 2'h0) begin
                matchCount_reg <= 2'h1;
            end else if (matchCount_reg != 2'h3) begin
                matchCount_reg <= matchCount_reg + 2'h1;
            end
        end
    end

    // store on the third identical word
    assign storeEn = rxWordValid && (rxWord == lastRxWord_reg)
                     && (matchCount_reg == 2'h2);

    // partner word store, base or next page share the location
    annp_word_store u_partner_word (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .loadEn   (storeEn),
        .loadData (rxWord),
        .wordOut  (partnerWord)
    );

    // ======================================================
    // page kind and partner capabilities captured with the word
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            partnerWordIsNext <= 1'b0;
            partnerNp_reg     <= 1'b0;
            partnerMore_reg   <= 1'b0;
        end else if (storeEn) begin
            partnerWordIsNext <= rxIsNextPage;
            partnerMore_reg   <= rxWord[`ANNP_BIT_MORE_PAGES];
            if (!rxIsNextPage) begin
                partnerNp_reg <= rxWord[`ANNP_BIT_MORE_PAGES];
            end
        end
    end

    // partner autoneg ability and local next-page ability levels
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            partnerAn_reg    <= 1'b0;
            localNp_reg      <= 1'b0;
            localNextPageAdv <= 1'b0;
        end else begin
            partnerAn_reg    <= partnerAutonegAble;
            localNp_reg      <= localNextPageAble;
            localNextPageAdv <= localNextPageAble;
        end
    end

    // ======================================================
    // sticky flags: set wins over the read clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pdFault_reg <= 1'b0;
        end else if (waitTimerDone && linkReadyCount != 2'h1) begin
            pdFault_reg <= 1'b1;
        end else if (readExp) begin
            pdFault_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pageRcvd_reg <= 1'b0;
        end else if (storeEn) begin
            pageRcvd_reg <= 1'b1;
        end else if (readExp) begin
            pageRcvd_reg <= 1'b0;
        end
    end

    // expansion word, reserved bits zero, no write path
    always_comb begin
        expWord                       = 16'h0000;
        expWord[`ANNP_BIT_PDFAULT]    = pdFault_reg;
        expWord[`ANNP_BIT_PARTNER_NP] = partnerNp_reg;
        expWord[`ANNP_BIT_LOCAL_NP]   = localNp_reg;
        expWord[`ANNP_BIT_PAGE_RCVD]  = pageRcvd_reg;
        expWord[`ANNP_BIT_PARTNER_AN] = partnerAn_reg;
    end

    // ======================================================
    // transmit word, null message page until station writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txWord_reg <= `ANNP_TX_RESET;
        end else if (writeTx) begin
            txWord_reg <= mgmtReq.wrData & `ANNP_TX_WRITE_MASK;
        end
    end

    // toggle tracks the last link code word sent
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prevToggle_reg <= 1'b1;
        end else if (txPageTaken) begin
            prevToggle_reg <= ~prevToggle_reg;
        end
    end

    // outgoing page: station fields, hardware toggle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txPage <= '0;
        end else begin
            txPage.morePagesFlag   <= txWord_reg[`ANNP_BIT_MORE_PAGES];
            txPage.ackFlag         <= 1'b0;
            txPage.messagePageFlag <= txWord_reg[`ANNP_BIT_MESSAGE_PAGE];
            txPage.taskCapableAck  <= txWord_reg[`ANNP_BIT_TASK_ACK];
            txPage.pageToggleBit   <= ~prevToggle_reg;
            txPage.pagePayload     <= txWord_reg[`ANNP_PAYLOAD_MSB:0];
        end
    end

    // exchange ends when neither side has more pages
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exchangeDone <= 1'b0;
        end else begin
            exchangeDone <= partnerWordIsNext && !partnerMore_reg
                            && !txWord_reg[`ANNP_BIT_MORE_PAGES];
        end
    end

    // ======================================================
    // read data select
    always_comb begin
        case (mgmtReq.addr)
            `ANNP_ADDR_PARTNER_WORD:  rdMux = partnerWord;
            `ANNP_ADDR_EXPANSION:     rdMux = expWord;
            `ANNP_ADDR_TRANSMIT_WORD: rdMux = txWord_reg;
            default:                  rdMux = 16'h0000;
        endcase
    end

    // read sequencer: answer one cycle after the strobe
    always_comb begin
        case (rdState_reg)
            annp_pkg::ANNP_IDLE: rdState_next = mgmtReq.rdStrobe ? annp_pkg::ANNP_READ
                                                                 : annp_pkg::ANNP_IDLE;
            annp_pkg::ANNP_READ: rdState_next = mgmtReq.rdStrobe ? annp_pkg::ANNP_READ
                                                                 : annp_pkg::ANNP_DONE;
            annp_pkg::ANNP_DONE: rdState_next = mgmtReq.rdStrobe ? annp_pkg::ANNP_READ
                                                                 : annp_pkg::ANNP_IDLE;
            default:             rdState_next = annp_pkg::ANNP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdState_reg <= annp_pkg::ANNP_IDLE;
        end else begin
            rdState_reg <= rdState_next;
        end
    end

    // registered read answer, captured before the clear lands
    // valid follows the sequencer so it pulses once per accepted read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mgmtRdValid <= 1'b0;
            mgmtRdData  <= 16'h0000;
        end else begin
            mgmtRdValid <= (rdState_next == annp_pkg::ANNP_READ);
            if (mgmtReq.rdStrobe) begin
                mgmtRdData <= rdMux;
            end
        end
    end

endmodule

// ==== autoneg_next_page_regs_monitor.sv ====
`timescale 1ns/100ps
// ==========================================================
// port-level checker for the next-page register block
module annp_regs_monitor (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    input  wire annp_pkg::annp_mgmt_req_t mgmtReq,
    input  wire logic                     mgmtRdValid,
    input  wire logic [15:0]              mgmtRdData,
    input  wire logic                     rxWordValid,
    input  wire logic                     waitTimerDone,
    input  wire logic [1:0]               linkReadyCount,
    input  wire logic                     localNextPageAble,
    input  wire logic                     localNextPageAdv,
    input  wire logic                     txPageTaken,
    input  wire annp_pkg::annp_page_t     txPage
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // decoded read strobes
    logic rdExp;
    logic rdTx;
    assign rdExp = mgmtReq.rdStrobe && (mgmtReq.addr == 5'h06);
    assign rdTx  = mgmtReq.rdStrobe && (mgmtReq.addr == 5'h07);

    a_read_answer: assert property (mgmtReq.rdStrobe |=> mgmtRdValid)
        else $error("read answer missing");
    a_no_extra_valid: assert property (!mgmtReq.rdStrobe |=> !mgmtRdValid)
        else $error("read valid without request");
    a_data_hold: assert property (!mgmtReq.rdStrobe |=> $stable(mgmtRdData))
        else $error("read data moved without read");
    a_exp_reserved_zero: assert property (rdExp |=> mgmtRdData[15:5] == 11'h000)
        else $error("expansion reserved bits not zero");
    a_tx_bit_zero: assert property (rdTx |=> !mgmtRdData[14] && !txPage.ackFlag)
        else $error("transmit bit 14 not zero");
    a_fault_seen: assert property (waitTimerDone && linkReadyCount != 2'h1 ##1 rdExp
        |=> mgmtRdData[4])
        else $error("parallel fault not reported");
    a_fault_cleared: assert property (rdExp && !waitTimerDone ##1 !waitTimerDone
        ##1 rdExp && !waitTimerDone |=> !mgmtRdData[4])
        else $error("parallel fault not cleared by read");
    a_adv_copy: assert property (1'b1 |=> localNextPageAdv == $past(localNextPageAble))
        else $error("local next-page indication not copied");
    a_toggle_flip: assert property (txPageTaken |-> ##[1:2] $changed(txPage.pageToggleBit))
        else $error("toggle did not invert");

    // main scenarios reached
    c_exp_read: cover property (rdExp ##1 mgmtRdValid);
    c_fault: cover property (waitTimerDone && linkReadyCount != 2'h1);
    c_triple: cover property (rxWordValid [*3]);
    c_take: cover property (txPageTaken);
endmodule

bind autoneg_next_page_regs annp_regs_monitor annp_regs_monitor_inst (.ref_clk, .rstn,
    .mgmtReq, .mgmtRdValid, .mgmtRdData, .rxWordValid, .waitTimerDone, .linkReadyCount,
    .localNextPageAble, .localNextPageAdv, .txPageTaken, .txPage);

// ==== autoneg_next_page_regs_tb.sv ====
`timescale 1ns/100ps
// ==========================================================
// register-level bench for the next-page block
module autoneg_next_page_regs_tb;
    logic                     ref_clk;
    logic                     rstn;
    annp_pkg::annp_mgmt_req_t mgmtReq;
    logic                     mgmtRdValid;
    logic [15:0]              mgmtRdData;
    logic                     rxWordValid;
    logic [15:0]              rxWord;
    logic                     rxIsNextPage;
    logic                     waitTimerDone;
    logic [1:0]               linkReadyCount;
    logic                     partnerAutonegAble;
    logic                     localNextPageAble;
    logic                     txPageTaken;
    annp_pkg::annp_page_t     txPage;
    logic                     localNextPageAdv;
    logic                     exchangeDone;
    logic                     partnerWordIsNext;
    int                       errors;
    int                       checked;

    autoneg_next_page_regs autoneg_next_page_regs_inst (.ref_clk, .rstn, .mgmtReq,
        .mgmtRdValid, .mgmtRdData, .rxWordValid, .rxWord, .rxIsNextPage, .waitTimerDone,
        .linkReadyCount, .partnerAutonegAble, .localNextPageAble, .txPageTaken, .txPage,
        .localNextPageAdv, .exchangeDone, .partnerWordIsNext);
    annp_partner_model annp_partner_model_inst (.ref_clk, .rxWordValid, .rxWord,
        .rxIsNextPage, .txPageTaken);

    // ==========================================================
    // access tasks
    task automatic cyc();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmtReq = '{1'b0, 1'b1, a, d};
        cyc();
        mgmtReq = '0;
        cyc(); // idle edge so the next strobe is a fresh request
    endtask
    // read with a compare mask, then one idle cycle
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
        mgmtReq = '{1'b1, 1'b0, a, 16'h0000};
        cyc();
        mgmtReq = '0;
        chk("read valid", {15'h0000, mgmtRdValid}, 16'h0001);
        chk("read data", mgmtRdData & m, exp);
        cyc();
    endtask
    task automatic fault(input logic [1:0] n);
        waitTimerDone  = 1'b1;
        linkReadyCount = n;
        cyc();
        waitTimerDone  = 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        errors             = 0;
        checked            = 0;
        rstn               = 1'b0;
        mgmtReq            = '0;
        waitTimerDone      = 1'b0;
        linkReadyCount     = 2'h0;
        partnerAutonegAble = 1'b0;
        localNextPageAble  = 1'b0;
        repeat (8) cyc();
        rstn = 1'b1;
        rd(5'h07, 16'h2001, 16'hFFFF);
        chk("tx page", txPage, 16'h2001);
        rd(5'h05, 16'h0000, 16'hFFFF);
        rd(5'h06, 16'h0000, 16'hFFFF);
        rd(5'h1F, 16'h0000, 16'hFFFF);
        wr(5'h07, 16'hFFFF);
        rd(5'h07, 16'hBFFF, 16'hFFFF);
        chk("tx page", txPage, 16'hB7FF);
        for (int i = 0; i < 2; i++) begin
            annp_partner_model_inst.take();
            repeat (2) cyc();
            chk("tx toggle", {15'h0000, txPage.pageToggleBit}, {15'h0000, i == 0});
        end
        // base page stored after three copies
        partnerAutonegAble = 1'b1;
        localNextPageAble  = 1'b1;
        wr(5'h06, 16'hFFFF);
        annp_partner_model_inst.send(16'h8001, 1'b0, 3);
        rd(5'h06, 16'h000F, 16'hFFFF);
        rd(5'h06, 16'h000D, 16'hFFFF);
        rd(5'h05, 16'h8001, 16'hFFFF);
        chk("adv", {15'h0000, localNextPageAdv}, 16'h0001);
        chk("is next", {15'h0000, partnerWordIsNext}, 16'h0000);
        // broken run of words is not stored
        annp_partner_model_inst.send(16'hD5AA, 1'b1, 2);
        annp_partner_model_inst.send(16'h4321, 1'b1, 1);
        rd(5'h06, 16'h0000, 16'h0002);
        wr(5'h05, 16'hFFFF);
        rd(5'h05, 16'h8001, 16'hFFFF);
        annp_partner_model_inst.send(16'h4321, 1'b1, 2);
        rd(5'h05, 16'h4321, 16'hFFFF);
        chk("is next", {15'h0000, partnerWordIsNext}, 16'h0001);
        rd(5'h06, 16'h0002, 16'h0002);
        // exchange ends only when both sides are finished
        chk("done", {15'h0000, exchangeDone}, 16'h0000);
        wr(5'h07, 16'h2001);
        cyc();
        chk("done", {15'h0000, exchangeDone}, 16'h0001);
        annp_partner_model_inst.send(16'hD5AA, 1'b1, 3);
        rd(5'h05, 16'hD5AA, 16'hFFFF);
        chk("done", {15'h0000, exchangeDone}, 16'h0000);
        // parallel detection fault for every ready count
        for (int n = 0; n < 4; n++) begin
            fault(2'(n));
            rd(5'h06, (n == 1) ? 16'h0000 : 16'h0010, 16'h0010);
            rd(5'h06, 16'h0000, 16'h0010);
        end
        end_sim();
    end
endmodule
